// >>> verilog/dcff_fifo_top.sv
// Purpose: 9-bit fifo with write and read sides, status flags and retransmit
// Assumes: WCLK_EN and RCLK_EN mark write and read clock edges of the sides
// Notes: FULL_FLAG_N is input ready (active low) and EMPTY_FLAG_N output ready
//        (active low) when fall-through mode is set
// Notes on behaviour
// - stored words leave on a nine bit output bus.
// - standard mode, full flag returns high one write edge after space frees.
// - standard mode, empty flag returns high 60 ns plus one read edge after a write.
// - first word readable after 60 ns plus one read edge, two in fall-through.
// - fall-through, output ready goes low 60 ns plus two read edges after a write.
// - almost empty goes high one read edge after level passes the offset.
// - fall-through, input ready goes low one write edge after space frees.
// - almost full goes high one write edge after level drops below threshold.
// - standard mode, after retransmit, empty stays low 60 ns plus one read edge.
// - fall-through retransmit done when output ready low, 60 ns plus two read edges.
// - serial offset load shifts bits 0 to 13 per write edge, each offset.
// - almost full changes only on write edges or a reset (partial reset sets it high).
// - threshold depth is memory size, plus one word in fall-through.
// - a full indication blocks writes until space is freed.
// - output ready rises only on a true read, a retransmit or a partial reset; last word stays out.
// - half full falls on a write past half, rises on a read back.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo_top
    import dcff_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PARTIAL_RESET_N,
    input wire logic WCLK_EN,
    input wire logic WEN_N,
    input wire logic [DATA_W-1:0] DATA_IN,
    input wire logic OFFSET_LOAD_N,
    input wire logic SERIAL_EN_N,
    input wire logic SERIAL_IN,
    input wire logic RCLK_EN,
    input wire logic REN_N,
    input wire logic RETRANSMIT_N,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic FULL_FLAG_N,
    output logic EMPTY_FLAG_N,
    output logic ALMOST_FULL_N,
    output logic ALMOST_EMPTY_N,
    output logic HALF_FULL_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP
);
    logic [DATA_W-1:0] mem [0:DEPTH_WORDS-1];
    logic fall_through_mode;
    logic serial_mode;
    logic strap_pending;
    logic [SHIFT_W-1:0] offsets;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_seen;
    logic [PTR_W-1:0] rd_seen;
    logic out_valid;
    logic fall_through_mode_arm;
    logic raw_empty_q;
    logic [HOLD_W-1:0] hold;
    dcff_reg_req_type reg_req;
    dcff_flags_type status_flags;
    logic [31:0] reg_rdata;

    wire logic part_clr = ~PARTIAL_RESET_N;

    // offsets and thresholds
    wire logic [ADDR_W-1:0] empty_offset = offsets[ADDR_W-1:0];
    wire logic [ADDR_W-1:0] full_offset = offsets[SHIFT_W-1:ADDR_W];
    wire logic [PTR_W-1:0] fall_through_mode_add = PTR_W'(fall_through_mode);
    wire logic [PTR_W-1:0] depth_eff = DEPTH_STD + fall_through_mode_add;
    wire logic [PTR_W-1:0] half_eff = HALF_STD + fall_through_mode_add;
    wire logic [PTR_W-1:0] af_limit = depth_eff - PTR_W'(full_offset);
    wire logic [PTR_W-1:0] ae_limit = PTR_W'(empty_offset) + fall_through_mode_add;

    // write side
    wire logic write_blocked = (FULL_FLAG_N == fall_through_mode);
    wire logic write_ok = WCLK_EN & ~WEN_N & ~write_blocked & ~part_clr;
    wire logic [PTR_W-1:0] wr_next = wr_ptr + PTR_W'(write_ok);
    wire logic [PTR_W-1:0] wlevel = wr_ptr - rd_seen;
    wire logic [PTR_W-1:0] wlevel_next = wr_next - rd_seen;
    wire logic full_now = (wlevel_next >= depth_eff);
    wire logic next_full_flag_n = full_now ^ ~fall_through_mode;
    wire logic next_almost_full_n = ~(wlevel_next >= af_limit);

    // serial offset load, one bit per write edge
    wire logic serial_shift = serial_mode & WCLK_EN & ~OFFSET_LOAD_N & ~SERIAL_EN_N;
    wire logic [SHIFT_W-1:0] offsets_shifted = {SERIAL_IN, offsets[SHIFT_W-1:1]};

    // read side
    wire logic retransmit = RCLK_EN & ~RETRANSMIT_N;
    wire logic [PTR_W-1:0] avail = wr_seen - rd_ptr;
    wire logic latency_start = retransmit | (raw_empty_q & (avail != '0));
    wire logic hold_clear = (hold == '0) & ~latency_start;
    wire logic mem_has = (avail != '0) & hold_clear;
    wire logic rd_ok = RCLK_EN & ~REN_N & ~retransmit;
    wire logic std_read = rd_ok & EMPTY_FLAG_N & ~fall_through_mode;
    wire logic pop = rd_ok & out_valid & fall_through_mode;
    wire logic load = RCLK_EN & ~retransmit & fall_through_mode & mem_has & fall_through_mode_arm & (~out_valid | pop);
    wire logic take = std_read | load;
    wire logic [PTR_W-1:0] rd_next = rd_ptr + PTR_W'(take);
    wire logic next_out_valid = load | (out_valid & ~pop);
    wire logic [PTR_W-1:0] retired = rd_ptr - PTR_W'(out_valid);
    wire logic [PTR_W-1:0] rlevel_next = wr_seen - rd_next + PTR_W'(next_out_valid);
    wire logic std_has_next = (wr_seen != rd_next) & hold_clear;
    wire logic next_empty_flag_n = fall_through_mode ? ~next_out_valid : std_has_next;
    wire logic next_almost_empty_n = ~(rlevel_next <= ae_limit);
    wire logic [ADDR_W-1:0] rd_addr = rd_ptr[ADDR_W-1:0];

    // half full, set by write edges, cleared by read edges
    wire logic hf_set_low = write_ok & (wlevel_next > half_eff);
    wire logic hf_set_high = (take | pop) & (rlevel_next <= half_eff);

    // register access
    wire logic wr_ctrl = reg_req.wr & (reg_req.addr == REG_CTRL);
    wire logic wr_offs = reg_req.wr & (reg_req.addr == REG_OFFS) & ~serial_mode;
    wire logic [SHIFT_W-1:0] offsets_written = {reg_req.wdata[OFFS_FULL_LSB+ADDR_W-1:OFFS_FULL_LSB],
                                                reg_req.wdata[ADDR_W-1:0]};

    // pointer crossings
    dcff_ptr_sync u_wr_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clear(part_clr),
        .src_bin(wr_ptr),
        .dst_bin(wr_seen)
    );

    dcff_ptr_sync u_rd_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clear(part_clr),
        .src_bin(retired),
        .dst_bin(rd_seen)
    );

    // storage
    always_ff @(posedge CLK_SYS) begin
        if (write_ok) begin
            mem[wr_ptr[ADDR_W-1:0]] <= DATA_IN;
        end
    end

    // write pointer and write-edge flags
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wr_ptr <= '0;
            FULL_FLAG_N <= 1'b1;
            ALMOST_FULL_N <= 1'b1;
        end else if (part_clr) begin
            wr_ptr <= '0;
            FULL_FLAG_N <= ~fall_through_mode;
            ALMOST_FULL_N <= 1'b1;
        end else if (WCLK_EN) begin
            wr_ptr <= wr_next;
            FULL_FLAG_N <= next_full_flag_n;
            ALMOST_FULL_N <= next_almost_full_n;
        end
    end

    // read pointer, output register and read-edge flags
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rd_ptr <= '0;
            out_valid <= 1'b0;
            fall_through_mode_arm <= 1'b0;
            EMPTY_FLAG_N <= 1'b0;
            ALMOST_EMPTY_N <= 1'b0;
            DATA_OUT <= '0;
        end else if (part_clr) begin
            rd_ptr <= '0;
            out_valid <= 1'b0;
            fall_through_mode_arm <= 1'b0;
            EMPTY_FLAG_N <= fall_through_mode;
            ALMOST_EMPTY_N <= 1'b0;
        end else if (retransmit) begin
            rd_ptr <= '0;
            out_valid <= 1'b0;
            fall_through_mode_arm <= 1'b0;
            EMPTY_FLAG_N <= fall_through_mode;
        end else if (RCLK_EN) begin
            rd_ptr <= rd_next;
            out_valid <= next_out_valid;
            fall_through_mode_arm <= mem_has;
            EMPTY_FLAG_N <= next_empty_flag_n;
            ALMOST_EMPTY_N <= next_almost_empty_n;
            if (take) begin
                DATA_OUT <= mem[rd_addr];
            end
        end
    end

    // fixed first-word and retransmit latency
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || part_clr) begin
            hold <= '0;
            raw_empty_q <= 1'b1;
        end else begin
            raw_empty_q <= (avail == '0);
            if (latency_start) begin
                hold <= HOLD_CYC;
            end else if (!hold_clear) begin
                hold <= hold - HOLD_W'(1);
            end
        end
    end

    // half full
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || part_clr) begin
            HALF_FULL_N <= 1'b1;
        end else if (hf_set_low) begin
            HALF_FULL_N <= 1'b0;
        end else if (hf_set_high) begin
            HALF_FULL_N <= 1'b1;
        end
    end

    // mode, offset strap and offsets
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            fall_through_mode <= 1'b0;
            serial_mode <= 1'b0;
            strap_pending <= 1'b1;
            offsets <= '0;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            serial_mode <= OFFSET_LOAD_N;
            offsets <= OFFSET_LOAD_N ? {OFFS_DEF_HIGH, OFFS_DEF_HIGH} : {OFFS_DEF_LOW, OFFS_DEF_LOW};
        end else begin
            if (wr_ctrl) begin
                fall_through_mode <= reg_req.wdata[CTRL_FALL_THROUGH_MODE_BIT];
            end
            if (serial_shift) begin
                offsets <= offsets_shifted;
            end else if (wr_offs) begin
                offsets <= offsets_written;
            end
        end
    end

    // register read data
    assign status_flags.full_n = FULL_FLAG_N;
    assign status_flags.empty_n = EMPTY_FLAG_N;
    assign status_flags.almost_full_n = ALMOST_FULL_N;
    assign status_flags.almost_empty_n = ALMOST_EMPTY_N;
    assign status_flags.half_full_n = HALF_FULL_N;

    wire logic [31:0] rd_ctrl = {31'h0, fall_through_mode};
    wire logic [31:0] rd_offs = {2'h0, full_offset, 2'h0, empty_offset};
    wire logic [31:0] rd_stat = {27'h0, status_flags};
    wire logic [31:0] rd_level = {17'h0, wlevel};

    assign reg_rdata = (reg_req.addr == REG_CTRL) ? rd_ctrl :
                       (reg_req.addr == REG_OFFS) ? rd_offs :
                       (reg_req.addr == REG_STAT) ? rd_stat :
                       (reg_req.addr == REG_LEVEL) ? rd_level : 32'h0;

    dcff_ahb_slave u_bus (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .rdata(reg_rdata),
        .hreadyout(HREADYOUT),
        .hrdata(HRDATA),
        .hresp(HRESP),
        .req(reg_req)
    );
endmodule : dcff_fifo_top
`default_nettype wire

// >>> common/dcff_pkg.sv
// Purpose: shared constants, types and gray helpers for the dual-rate fifo
// Assumes: one system clock; write and read edges arrive as enable pulses
// Notes: depth fixed at the smaller variant, 16384 words of 9 bits
package dcff_pkg;
    localparam int DATA_W = 9;
    localparam int ADDR_W = 14;
    localparam int PTR_W = 15;
    localparam int SHIFT_W = 2 * ADDR_W;
    localparam int DEPTH_WORDS = 16384;
    localparam logic [PTR_W-1:0] DEPTH_STD = 15'h4000;
    localparam logic [PTR_W-1:0] HALF_STD = 15'h2000;
    localparam logic [ADDR_W-1:0] OFFS_DEF_LOW = 14'h007f;
    localparam logic [ADDR_W-1:0] OFFS_DEF_HIGH = 14'h03ff;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int FWL_NS = 60;
    localparam int FWL_CYC = (FWL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_W = 5;
    localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(FWL_CYC);
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_OFFS = 8'h04;
    localparam logic [REG_AW-1:0] REG_STAT = 8'h08;
    localparam logic [REG_AW-1:0] REG_LEVEL = 8'h0c;
    localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
    localparam int OFFS_FULL_LSB = 16;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic full_n;
        logic empty_n;
        logic almost_full_n;
        logic almost_empty_n;
        logic half_full_n;
    } dcff_flags_type;

    typedef struct packed {
        logic wr;
        logic [REG_AW-1:0] addr;
        logic [31:0] wdata;
    } dcff_reg_req_type;

    function automatic logic [PTR_W-1:0] dcff_bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : dcff_bin2gray

    function automatic logic [PTR_W-1:0] dcff_gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : dcff_gray2bin
endpackage : dcff_pkg

// >>> verilog/dcff_ptr_sync.sv
// Purpose: carry a pointer from one side of the fifo to the other
// Assumes: source pointer moves by at most one per cycle except on clear or, for the read side, on retransmit
// Notes: gray coded, two capture stages, binary again at the far end
`timescale 1ns/1ps
`default_nettype none
module dcff_ptr_sync
    import dcff_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic [PTR_W-1:0] src_bin,
    output logic [PTR_W-1:0] dst_bin
);
    logic [PTR_W-1:0] src_gray;
    logic [PTR_W-1:0] meta_gray;
    logic [PTR_W-1:0] dst_gray;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            src_gray <= '0;
            meta_gray <= '0;
            dst_gray <= '0;
        end else begin
            src_gray <= dcff_bin2gray(src_bin);
            meta_gray <= src_gray;
            dst_gray <= meta_gray;
        end
    end

    assign dst_bin = dcff_gray2bin(dst_gray);
endmodule : dcff_ptr_sync
`default_nettype wire

// >>> verilog/dcff_ahb_slave.sv
// Purpose: ahb-lite slave front end for the fifo registers
// Assumes: single word transfers; response always okay
// Notes: writes take no wait state, reads take one
`timescale 1ns/1ps
`default_nettype none
module dcff_ahb_slave
    import dcff_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] rdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output dcff_reg_req_type req
);
    logic dphase_wr;
    logic dphase_rd;
    logic [REG_AW-1:0] dphase_addr;

    wire logic addr_take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dphase_wr <= 1'b0;
            dphase_rd <= 1'b0;
            dphase_addr <= '0;
            hreadyout <= 1'b1;
            hrdata <= '0;
            hresp <= 1'b0;
        end else begin
            if (hready) begin
                dphase_wr <= addr_take & hwrite;
                dphase_rd <= addr_take & ~hwrite;
                dphase_addr <= haddr[REG_AW-1:0];
            end
            hreadyout <= ~(addr_take & ~hwrite);
            if (dphase_rd && !hreadyout) begin
                hrdata <= rdata;
            end
        end
    end

    assign req.wr = dphase_wr;
    assign req.addr = dphase_addr;
    assign req.wdata = hwdata;
endmodule : dcff_ahb_slave
`default_nettype wire

// >>> sim/dcff_side_model.sv
// Purpose: writer and reader sides of the fifo
// Assumes: write edge every 2nd cycle, read edge every 3rd
// Notes: data_in shows the inverse of the last word when idle
`timescale 1ns/1ps
`default_nettype none
module dcff_side_model
    import dcff_pkg::*;
(
    input wire logic clk,
    output logic wclk_en,
    output logic wen_n,
    output logic [DATA_W-1:0] data_in,
    output logic rclk_en,
    output logic ren_n,
    output logic retransmit_n
);
    logic [1:0] rdiv;
    initial begin
        wclk_en = 1'b0;
        wen_n = 1'b1;
        data_in = '0;
        rclk_en = 1'b0;
        ren_n = 1'b1;
        retransmit_n = 1'b1;
        rdiv = 2'h0;
    end
    always @(posedge clk) begin
        wclk_en <= ~wclk_en;
        rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
        rclk_en <= (rdiv == 2'h1);
    end
    // one word per write edge; callers keep to depth minus two before retransmit
    task automatic write_word(input logic [DATA_W-1:0] d);
        @(posedge clk iff !wclk_en);
        wen_n <= 1'b0;
        data_in <= d;
        @(posedge clk);
        wen_n <= 1'b1;
        data_in <= ~d;
    endtask : write_word
    // rt high makes a retransmit instead of a read
    task automatic read_op(input logic rt);
        @(posedge clk iff rdiv == 2'h1);
        ren_n <= rt;
        retransmit_n <= ~rt;
        @(posedge clk);
        ren_n <= 1'b1;
        retransmit_n <= 1'b1;
    endtask : read_op
endmodule : dcff_side_model
`default_nettype wire

// >>> sim/dcff_fifo_props.sv
// Purpose: port-level checks of the fifo flags and bus
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module from the bench
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo_props
    import dcff_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PARTIAL_RESET_N,
    input wire logic WCLK_EN,
    input wire logic WEN_N,
    input wire logic RCLK_EN,
    input wire logic RETRANSMIT_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic FULL_FLAG_N,
    input wire logic EMPTY_FLAG_N,
    input wire logic ALMOST_FULL_N,
    input wire logic ALMOST_EMPTY_N,
    input wire logic HALF_FULL_N
);
    logic rd_take;
    assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE && (HSIZE == HSIZE_WORD);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    chk_full_wedge: assert property ($changed(FULL_FLAG_N) && $past(PARTIAL_RESET_N) |-> $past(WCLK_EN))
        else $error("full flag moved off a write edge");
    chk_empty_redge: assert property ($changed(EMPTY_FLAG_N) && $past(PARTIAL_RESET_N) |-> $past(RCLK_EN))
        else $error("empty flag moved off a read edge");
    chk_afull_wedge: assert property ($changed(ALMOST_FULL_N) && $past(PARTIAL_RESET_N) |-> $past(WCLK_EN))
        else $error("almost full moved off a write edge");
    chk_aempty_redge: assert property ($rose(ALMOST_EMPTY_N) |-> $past(RCLK_EN))
        else $error("almost empty rose off a read edge");
    chk_half_fell: assert property ($fell(HALF_FULL_N) |-> $past(WCLK_EN) && $past(!WEN_N))
        else $error("half full fell off a write edge");
    chk_dout_hold: assert property ($changed(DATA_OUT) |-> $past(RCLK_EN))
        else $error("data out moved off a read edge");
    chk_rt_hold: assert property (RCLK_EN && !RETRANSMIT_N |=> ##1 $stable(EMPTY_FLAG_N) [*8])
        else $error("empty flag returned too soon after retransmit");
    chk_read_wait: assert property (rd_take |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("response not okay");
    cover property (rd_take);
    cover property ($fell(FULL_FLAG_N));
    cover property (RCLK_EN && !RETRANSMIT_N);
endmodule : dcff_fifo_props
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the fifo flags and registers
// Assumes: parallel offset load strapped at the first reset, serial at the last
// Notes: standard mode first, fall-through after a partial reset
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dcff_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} dcff_row_type;
    localparam logic [SHIFT_W-1:0] SER_VAL = 28'h0084012;
    logic CLK_SYS = 1'b0;
    logic RST_N, PARTIAL_RESET_N, HSEL, HWRITE, OFFSET_LOAD_N, SERIAL_EN_N, SERIAL_IN;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HADDR, HWDATA;
    logic WCLK_EN, WEN_N, RCLK_EN, REN_N, RETRANSMIT_N;
    logic [DATA_W-1:0] DATA_IN, DATA_OUT;
    logic FULL_FLAG_N, EMPTY_FLAG_N, ALMOST_FULL_N, ALMOST_EMPTY_N, HALF_FULL_N, HREADYOUT, HRESP;
    logic [31:0] HRDATA, rd;
    int n_mismatch = 0;
    int total_checks = 0;
    int lat;
    dcff_row_type rows [10];
    always #2 CLK_SYS = ~CLK_SYS;
    dcff_side_model dcff_side_model_inst (.clk(CLK_SYS), .wclk_en(WCLK_EN), .wen_n(WEN_N), .data_in(DATA_IN),
        .rclk_en(RCLK_EN), .ren_n(REN_N), .retransmit_n(RETRANSMIT_N));
    dcff_fifo_top dcff_fifo_top_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PARTIAL_RESET_N(PARTIAL_RESET_N),
        .WCLK_EN(WCLK_EN), .WEN_N(WEN_N), .DATA_IN(DATA_IN), .OFFSET_LOAD_N(OFFSET_LOAD_N),
        .SERIAL_EN_N(SERIAL_EN_N), .SERIAL_IN(SERIAL_IN), .RCLK_EN(RCLK_EN), .REN_N(REN_N),
        .RETRANSMIT_N(RETRANSMIT_N), .DATA_OUT(DATA_OUT),
        .FULL_FLAG_N(FULL_FLAG_N), .EMPTY_FLAG_N(EMPTY_FLAG_N), .ALMOST_FULL_N(ALMOST_FULL_N),
        .ALMOST_EMPTY_N(ALMOST_EMPTY_N), .HALF_FULL_N(HALF_FULL_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
        .HRDATA(HRDATA), .HRESP(HRESP));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic guard(input int k);
        if (k > 400) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : guard
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1) begin
            @(posedge CLK_SYS);
            k++;
            guard(k);
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HSIZE <= HSIZE_WORD;
        wait_rdy();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        rd = HRDATA;
        HSEL <= 1'b0;
    endtask : bus
    function automatic logic flag(input int s);
        return (s == 0) ? EMPTY_FLAG_N : (s == 1) ? FULL_FLAG_N : ALMOST_EMPTY_N;
    endfunction : flag
    task automatic wait_on(input int s, input logic v);
        lat = 0;
        while (flag(s) !== v) begin
            @(posedge CLK_SYS);
            lat++;
            guard(lat);
        end
    endtask : wait_on
    task automatic part_reset;
        @(posedge CLK_SYS);
        PARTIAL_RESET_N <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        PARTIAL_RESET_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
    endtask : part_reset
    initial begin
        RST_N = 1'b0;
        PARTIAL_RESET_N = 1'b1;
        HSEL = 1'b0;
        HWRITE = 1'b0;
        HTRANS = 2'h0;
        HSIZE = 3'h0;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        OFFSET_LOAD_N = 1'b0;
        SERIAL_EN_N = 1'b1;
        SERIAL_IN = 1'b0;
        rows = '{'{1'b0, REG_STAT, 32'h0, 32'h15}, '{1'b0, REG_OFFS, 32'h0, 32'h007f007f},
            '{1'b1, REG_OFFS, 32'h00050003, 32'h0}, '{1'b0, REG_OFFS, 32'h0, 32'h00050003},
            '{1'b0, REG_CTRL, 32'h0, 32'h0}, '{1'b0, REG_LEVEL, 32'h0, 32'h0}, '{1'b1, 8'h10, 32'hffffffff, 32'h0},
            '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b1, REG_STAT, 32'h0, 32'h0}, '{1'b0, REG_STAT, 32'h0, 32'h15}};
        repeat (20) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        foreach (rows[r]) begin
            bus(rows[r].wr, rows[r].a, rows[r].d);
            if (!rows[r].wr) begin
                cmp(rd, rows[r].e);
            end
        end
        dcff_side_model_inst.write_word(9'h100);
        wait_on(0, 1'b1);
        cmp(32'(lat >= FWL_CYC && lat <= FWL_CYC + 10), 32'h1);
        dcff_side_model_inst.write_word(9'h101);
        dcff_side_model_inst.write_word(9'h102);
        repeat (8) @(posedge CLK_SYS);
        cmp(32'(ALMOST_EMPTY_N), 32'h0);
        dcff_side_model_inst.write_word(9'h103);
        wait_on(2, 1'b1);
        cmp(32'(lat <= 8), 32'h1);
        for (int k = 0; k < 2; k++) begin
            dcff_side_model_inst.read_op(1'b0);
            #1;
            cmp(32'(DATA_OUT), 32'(9'h100 + k));
        end
        dcff_side_model_inst.read_op(1'b1);
        #1;
        cmp(32'(EMPTY_FLAG_N), 32'h0);
        wait_on(0, 1'b1);
        cmp(32'(lat >= FWL_CYC), 32'h1);
        dcff_side_model_inst.read_op(1'b0);
        #1;
        cmp(32'(DATA_OUT), 32'h100);
        part_reset();
        for (int k = 1; k <= DEPTH_WORDS + 1; k++) begin
            dcff_side_model_inst.write_word(9'(k));
            #1;
            case (k)
                8192: cmp(32'(HALF_FULL_N), 32'h1);
                8193: cmp(32'(HALF_FULL_N), 32'h0);
                16378: cmp(32'(ALMOST_FULL_N), 32'h1);
                16379: cmp(32'(ALMOST_FULL_N), 32'h0);
                16383: cmp(32'(FULL_FLAG_N), 32'h1);
                16384: cmp(32'(FULL_FLAG_N), 32'h0);
                default: ;
            endcase
        end
        bus(1'b0, REG_LEVEL, 32'h0);
        cmp(rd, 32'h4000);
        dcff_side_model_inst.read_op(1'b0);
        #1;
        cmp(32'(DATA_OUT), 32'h1);
        wait_on(1, 1'b1);
        cmp(32'(lat <= 8), 32'h1);
        cmp(32'(ALMOST_FULL_N), 32'h0);
        bus(1'b1, REG_CTRL, 32'h1);
        part_reset();
        cmp(32'(FULL_FLAG_N), 32'h0);
        cmp(32'(EMPTY_FLAG_N), 32'h1);
        dcff_side_model_inst.write_word(9'h1a5);
        wait_on(0, 1'b0);
        cmp(32'(lat >= FWL_CYC && lat <= FWL_CYC + 12), 32'h1);
        cmp(32'(DATA_OUT), 32'h1a5);
        dcff_side_model_inst.read_op(1'b0);
        wait_on(0, 1'b1);
        cmp(32'(DATA_OUT), 32'h1a5);
        OFFSET_LOAD_N <= 1'b1;
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        cmp(32'(EMPTY_FLAG_N), 32'h0);
        cmp(32'(FULL_FLAG_N), 32'h1);
        bus(1'b1, REG_OFFS, 32'h00050003);
        bus(1'b0, REG_OFFS, 32'h0);
        cmp(rd, 32'h03ff03ff);
        OFFSET_LOAD_N <= 1'b0;
        for (int k = 0; k < SHIFT_W; k++) begin
            @(posedge CLK_SYS iff !WCLK_EN);
            SERIAL_EN_N <= 1'b0;
            SERIAL_IN <= SER_VAL[k];
            @(posedge CLK_SYS);
            SERIAL_EN_N <= 1'b1;
        end
        bus(1'b0, REG_OFFS, 32'h0);
        cmp(rd, 32'h00210012);
        print_verdict();
    end
endmodule : tb_top
bind dcff_fifo_top dcff_fifo_props dcff_fifo_props_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .PARTIAL_RESET_N(PARTIAL_RESET_N), .WCLK_EN(WCLK_EN), .WEN_N(WEN_N), .RCLK_EN(RCLK_EN),
    .RETRANSMIT_N(RETRANSMIT_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .DATA_OUT(DATA_OUT), .FULL_FLAG_N(FULL_FLAG_N), .EMPTY_FLAG_N(EMPTY_FLAG_N),
    .ALMOST_FULL_N(ALMOST_FULL_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N), .HALF_FULL_N(HALF_FULL_N));
`default_nettype wire
